// ### include/rpc_pkg.sv
// Constants and types shared by the record path control register bank.
`default_nettype none
package rpc_pkg;
  // Register addresses as seen on the device's control port.
  localparam int unsigned RPC_NREG = 4;
  localparam int unsigned RPC_IDX_BEEP = 0;
  localparam int unsigned RPC_IDX_PWR = 1;
  localparam int unsigned RPC_IDX_LEFT = 2;
  localparam int unsigned RPC_IDX_RIGHT = 3;
  localparam logic [15:0] RPC_ADDR [RPC_NREG] = '{16'h4008, 16'h4009, 16'h400e, 16'h400f};
  // Writable bits of each register; reserved bits are cleared on write and read as zero.
  localparam logic [7:0] RPC_MASK [RPC_NREG] = '{8'h3f, 8'h7e, 8'he7, 8'he7};
  localparam logic [7:0] RPC_RST [RPC_NREG] = '{8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RPC_RD_NONE = 8'h00;

  // Digital microphone and beep control fields.
  localparam int unsigned RPC_DMIC_LSB = 4;
  localparam int unsigned RPC_DMIC_W = 2;
  localparam logic [1:0] RPC_DMIC_ONE = 2'h1;
  localparam logic [1:0] RPC_DMIC_TWO = 2'h2;
  localparam int unsigned RPC_BEEP_UNMUTE_BIT = 3;
  localparam int unsigned RPC_BEEP_GAIN_LSB = 0;
  localparam int unsigned RPC_GAIN_W = 3;

  // Record power management fields.
  localparam int unsigned RPC_BOOST_LSB = 5;
  localparam int unsigned RPC_ADC_BIAS_LSB = 3;
  localparam int unsigned RPC_FE_BIAS_LSB = 1;
  localparam int unsigned RPC_MODE_W = 2;

  // Input amplifier control fields, same layout on both channels.
  localparam int unsigned RPC_AMP_GAIN_LSB = 5;
  localparam int unsigned RPC_AMP_SE_BIT = 2;
  localparam int unsigned RPC_AMP_UNMUTE_BIT = 1;
  localparam int unsigned RPC_AMP_EN_BIT = 0;

  // Bias field encodings.
  localparam logic [1:0] RPC_CODE_NORMAL = 2'h0;
  localparam logic [1:0] RPC_CODE_EXTREME = 2'h1;
  localparam logic [1:0] RPC_CODE_SAVING = 2'h2;
  localparam logic [1:0] RPC_CODE_ENHANCED = 2'h3;

  // Gain in dB for each code, signed for the beep path.
  localparam logic signed [6:0] RPC_BEEP_DB [8] = '{7'sh00, 7'sh06, 7'sh0a, 7'sh0e, 7'sh69, 7'sh14, 7'sh1a, 7'sh20};
  localparam logic [5:0] RPC_AMP_DB [8] = '{6'h00, 6'h06, 6'h0a, 6'h0e, 6'h11, 6'h14, 6'h1a, 6'h20};
  localparam logic signed [6:0] RPC_BEEP_DB_MAX = 7'sh20;
  localparam logic signed [6:0] RPC_BEEP_DB_ATTEN = 7'sh69;
  localparam logic [2:0] RPC_BEEP_CODE_MAX = 3'h7;
  localparam logic [2:0] RPC_BEEP_CODE_ATTEN = 3'h4;

  typedef enum logic [1:0] {
    RPC_MODE_NORMAL,
    RPC_MODE_POWER_SAVING,
    RPC_MODE_ENHANCED,
    RPC_MODE_EXTREME_SAVING
  } rpc_pmode_t;
endpackage : rpc_pkg
`default_nettype wire

// ### logic/rpc_regs.sv
// Record path control register bank with decoded, registered control outputs.
`default_nettype none
// How it works
// - Digital mic field picks mic one or two; selecting one powers down analog front end.
// - Beep mute bit silences the analog beep input while in muting state (0).
// - Beep gain resets to 0 dB; codes step 0,6,10,14,20,26,32 dB.
// - Beep gain code 100 gives -23 dB attenuation instead of a gain step.
// - Record power register offers normal, saving, enhanced and extreme saving modes.
// - Mixer boost field: 00 normal, 01..11 boost levels one to three; resets normal.
// - Converter bias: 00 normal, 01 extreme, 10 saving, 11 enhanced; resets 00.
// - Front-end bias uses the converter bias encoding and resets to normal.
// - Left gain codes give 0,6,10,14,17,20,26,32 dB; resets to 0 dB.
// - Left single-ended bit uses single pin, drops positive pin, ties complement to common.
// - Left mute bit 0 mutes, 1 unmutes; resets muted.
// - Left enable bit 1 powers the left amplifier unless a digital mic is selected; resets disabled.
// - Right gain mirrors left gain: eight steps 0 to 32 dB, resets 0 dB.
// - Right single-ended bit uses single pin, drops positive pin, ties complement to common.
// - Right mute bit 0 mutes whole right amplifier, 1 unmutes; resets muted.
// - Right enable bit 1 powers the right amplifier unless a digital mic is selected; resets disabled.
module rpc_regs (
  input wire logic ref_clk, // Control clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; all state holds while low.
  input wire logic [15:0] reg_addr, // Register address from the control port.
  input wire logic reg_wr_en, // Write strobe.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_rd_en, // Read strobe.
  output logic [7:0] reg_rdata, // Read data, valid with reg_rvalid.
  output logic reg_rvalid, // Read answer pulse.
  output logic digital_mic_input_one_en, // Digital mic one selected.
  output logic digital_mic_input_two_en, // Digital mic two selected.
  output logic analog_front_end_pd, // Analog record front end powered down.
  output logic beep_muted, // Beep input path muted.
  output logic signed [6:0] beep_gain_db, // Beep gain in dB.
  output logic [1:0] mixer_boost_level, // Mixer boost level, 0 is normal.
  output var rpc_pkg::rpc_pmode_t adc_bias_mode, // Converter bias mode.
  output var rpc_pkg::rpc_pmode_t front_end_bias_mode, // Input amplifier and mixer bias mode.
  output logic [5:0] left_gain_db, // Left amplifier gain in dB.
  output logic left_single_ended_input_pin_en, // Left single-ended pin in use.
  output logic left_positive_diff_input_pin_en, // Left positive differential pin in use.
  output logic left_complement_to_cm, // Left complementary input tied to common mode.
  output logic left_amp_muted, // Left amplifier muted.
  output logic left_amp_powered, // Left amplifier powered.
  output logic [5:0] right_gain_db, // Right amplifier gain in dB.
  output logic right_single_ended_input_pin_en, // Right single-ended pin in use.
  output logic right_positive_diff_input_pin_en, // Right positive differential pin in use.
  output logic right_complement_to_cm, // Right complementary input tied to common mode.
  output logic right_amp_muted, // Right amplifier muted.
  output logic right_amp_powered // Right amplifier powered.
);
  import rpc_pkg::*;

  logic [7:0] regs [RPC_NREG];
  logic [7:0] beep_r;
  logic [7:0] pwr_r;
  logic [7:0] left_r;
  logic [7:0] right_r;
  logic dmic_active;

  // Returns true when the address selects register idx.
  function automatic logic rpc_hit(input logic [15:0] addr, input int unsigned idx);
    rpc_hit = (addr == RPC_ADDR[idx]);
  endfunction : rpc_hit

  // Read multiplexer; an unmapped address answers zero.
  function automatic logic [7:0] rpc_read(input logic [15:0] addr, input logic [7:0] r0,
                                          input logic [7:0] r1, input logic [7:0] r2,
                                          input logic [7:0] r3);
    logic [7:0] v;
    v = RPC_RD_NONE;
    if (rpc_hit(addr, RPC_IDX_BEEP)) begin
      v = r0;
    end else if (rpc_hit(addr, RPC_IDX_PWR)) begin
      v = r1;
    end else if (rpc_hit(addr, RPC_IDX_LEFT)) begin
      v = r2;
    end else if (rpc_hit(addr, RPC_IDX_RIGHT)) begin
      v = r3;
    end
    rpc_read = v;
  endfunction : rpc_read

  // Maps a two-bit bias code onto the four power modes.
  function automatic rpc_pmode_t rpc_mode(input logic [1:0] code);
    rpc_pmode_t m;
    case (code)
      RPC_CODE_NORMAL: m = RPC_MODE_NORMAL;
      RPC_CODE_EXTREME: m = RPC_MODE_EXTREME_SAVING;
      RPC_CODE_SAVING: m = RPC_MODE_POWER_SAVING;
      RPC_CODE_ENHANCED: m = RPC_MODE_ENHANCED;
      default: m = RPC_MODE_NORMAL;
    endcase
    rpc_mode = m;
  endfunction : rpc_mode

  // Register storage: reserved bits are masked off so they can never be set.
  generate
    for (genvar i = 0; i < RPC_NREG; i++) begin : g_reg
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          regs[i] <= RPC_RST[i];
        end else if (ce && reg_wr_en && rpc_hit(reg_addr, i)) begin
          regs[i] <= reg_wdata & RPC_MASK[i];
        end
      end
    end
  endgenerate

  assign beep_r = regs[RPC_IDX_BEEP];
  assign pwr_r = regs[RPC_IDX_PWR];
  assign left_r = regs[RPC_IDX_LEFT];
  assign right_r = regs[RPC_IDX_RIGHT];

  // Read port answers one cycle after the strobe.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= RPC_RD_NONE;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rpc_read(reg_addr, beep_r, pwr_r, left_r, right_r);
      end
    end
  end

  // The reserved code 11 selects no microphone, so the analog path stays usable.
  assign dmic_active = (beep_r[RPC_DMIC_LSB +: RPC_DMIC_W] == RPC_DMIC_ONE) ||
                       (beep_r[RPC_DMIC_LSB +: RPC_DMIC_W] == RPC_DMIC_TWO);

  // Microphone and beep controls.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      digital_mic_input_one_en <= 1'b0;
      digital_mic_input_two_en <= 1'b0;
      analog_front_end_pd <= 1'b0;
      beep_muted <= 1'b1;
      beep_gain_db <= RPC_BEEP_DB[0];
    end else if (ce) begin
      digital_mic_input_one_en <= (beep_r[RPC_DMIC_LSB +: RPC_DMIC_W] == RPC_DMIC_ONE);
      digital_mic_input_two_en <= (beep_r[RPC_DMIC_LSB +: RPC_DMIC_W] == RPC_DMIC_TWO);
      analog_front_end_pd <= dmic_active;
      beep_muted <= !beep_r[RPC_BEEP_UNMUTE_BIT];
      beep_gain_db <= RPC_BEEP_DB[beep_r[RPC_BEEP_GAIN_LSB +: RPC_GAIN_W]];
    end
  end

  // Record power management.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mixer_boost_level <= RPC_CODE_NORMAL;
      adc_bias_mode <= RPC_MODE_NORMAL;
      front_end_bias_mode <= RPC_MODE_NORMAL;
    end else if (ce) begin
      mixer_boost_level <= pwr_r[RPC_BOOST_LSB +: RPC_MODE_W];
      adc_bias_mode <= rpc_mode(pwr_r[RPC_ADC_BIAS_LSB +: RPC_MODE_W]);
      front_end_bias_mode <= rpc_mode(pwr_r[RPC_FE_BIAS_LSB +: RPC_MODE_W]);
    end
  end

  // Left input amplifier; a selected digital mic overrides its power.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      left_gain_db <= RPC_AMP_DB[0];
      left_single_ended_input_pin_en <= 1'b0;
      left_positive_diff_input_pin_en <= 1'b1;
      left_complement_to_cm <= 1'b0;
      left_amp_muted <= 1'b1;
      left_amp_powered <= 1'b0;
    end else if (ce) begin
      left_gain_db <= RPC_AMP_DB[left_r[RPC_AMP_GAIN_LSB +: RPC_GAIN_W]];
      left_single_ended_input_pin_en <= left_r[RPC_AMP_SE_BIT];
      left_positive_diff_input_pin_en <= !left_r[RPC_AMP_SE_BIT];
      left_complement_to_cm <= left_r[RPC_AMP_SE_BIT];
      left_amp_muted <= !left_r[RPC_AMP_UNMUTE_BIT];
      left_amp_powered <= left_r[RPC_AMP_EN_BIT] && !dmic_active;
    end
  end

  // Right input amplifier; a selected digital mic overrides its power.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      right_gain_db <= RPC_AMP_DB[0];
      right_single_ended_input_pin_en <= 1'b0;
      right_positive_diff_input_pin_en <= 1'b1;
      right_complement_to_cm <= 1'b0;
      right_amp_muted <= 1'b1;
      right_amp_powered <= 1'b0;
    end else if (ce) begin
      right_gain_db <= RPC_AMP_DB[right_r[RPC_AMP_GAIN_LSB +: RPC_GAIN_W]];
      right_single_ended_input_pin_en <= right_r[RPC_AMP_SE_BIT];
      right_positive_diff_input_pin_en <= !right_r[RPC_AMP_SE_BIT];
      right_complement_to_cm <= right_r[RPC_AMP_SE_BIT];
      right_amp_muted <= !right_r[RPC_AMP_UNMUTE_BIT];
      right_amp_powered <= right_r[RPC_AMP_EN_BIT] && !dmic_active;
    end
  end

  // A write that selects digital mic one powers down the front end and the left amplifier two edges later.
  dmic_power_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && reg_wr_en && rpc_hit(reg_addr, RPC_IDX_BEEP) &&
    reg_wdata[RPC_DMIC_LSB +: RPC_DMIC_W] == RPC_DMIC_ONE ##1 ce |=> analog_front_end_pd && !left_amp_powered)
    else $error("Digital mic selected but analog front end not powered down.");

  beep_mute_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && !beep_r[RPC_BEEP_UNMUTE_BIT] |=> beep_muted)
    else $error("Beep path not muted while its mute bit is zero.");

  beep_gain_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && beep_r[RPC_BEEP_GAIN_LSB +: RPC_GAIN_W] == RPC_BEEP_CODE_MAX |=> beep_gain_db == RPC_BEEP_DB_MAX)
    else $error("Highest beep gain code does not give 32 dB.");

  beep_atten_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && beep_r[RPC_BEEP_GAIN_LSB +: RPC_GAIN_W] == RPC_BEEP_CODE_ATTEN |=> beep_gain_db == RPC_BEEP_DB_ATTEN)
    else $error("Beep gain code 100 does not give -23 dB.");

  boost_reset_a: assert property (
    @(posedge ref_clk)
    srst |=> mixer_boost_level == RPC_CODE_NORMAL && pwr_r == RPC_RST[RPC_IDX_PWR])
    else $error("Mixer boost not normal after reset.");

  adc_bias_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && pwr_r[RPC_ADC_BIAS_LSB +: RPC_MODE_W] == RPC_CODE_EXTREME |=> adc_bias_mode == RPC_MODE_EXTREME_SAVING)
    else $error("Converter bias code 01 is not extreme power saving.");

  fe_bias_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && pwr_r[RPC_FE_BIAS_LSB +: RPC_MODE_W] == RPC_CODE_SAVING |=> front_end_bias_mode == RPC_MODE_POWER_SAVING)
    else $error("Front-end bias code 10 is not power saving.");

  left_gain_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce |=> left_gain_db == RPC_AMP_DB[$past(left_r[RPC_AMP_GAIN_LSB +: RPC_GAIN_W])])
    else $error("Left gain does not follow its code.");

  left_single_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    left_single_ended_input_pin_en |-> !left_positive_diff_input_pin_en && left_complement_to_cm)
    else $error("Left single-ended mode leaves the positive pin in use.");

  left_mute_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && left_r[RPC_AMP_UNMUTE_BIT] |=> !left_amp_muted)
    else $error("Left amplifier muted while its unmute bit is one.");

  left_enable_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && !left_r[RPC_AMP_EN_BIT] |=> !left_amp_powered)
    else $error("Left amplifier powered while disabled.");

  right_gain_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce |=> right_gain_db == RPC_AMP_DB[$past(right_r[RPC_AMP_GAIN_LSB +: RPC_GAIN_W])])
    else $error("Right gain does not follow its code.");

  right_single_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && right_r[RPC_AMP_SE_BIT] |=> right_single_ended_input_pin_en && !right_positive_diff_input_pin_en)
    else $error("Right single-ended mode not applied.");

  right_mute_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && !right_r[RPC_AMP_UNMUTE_BIT] |=> right_amp_muted)
    else $error("Right amplifier unmuted while its mute bit is zero.");

  right_enable_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && right_r[RPC_AMP_EN_BIT] && !dmic_active |=> right_amp_powered)
    else $error("Right amplifier not powered while enabled.");

  reserved_read_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && reg_rd_en && rpc_hit(reg_addr, RPC_IDX_LEFT) |=> reg_rvalid && (reg_rdata & ~RPC_MASK[RPC_IDX_LEFT]) == 8'h00)
    else $error("Reserved bits of the left amplifier register read nonzero.");

  right_dmic_off_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && dmic_active |=> analog_front_end_pd && !right_amp_powered)
    else $error("Right amplifier powered while a digital mic is selected.");

  dmic_two_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && beep_r[RPC_DMIC_LSB +: RPC_DMIC_W] == RPC_DMIC_TWO |=> digital_mic_input_two_en && analog_front_end_pd)
    else $error("Digital mic two not selected by its code.");

  dmic_none_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && !dmic_active |=> !analog_front_end_pd && !digital_mic_input_one_en && !digital_mic_input_two_en)
    else $error("Analog front end powered down with no digital mic selected.");

  beep_unmute_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && beep_r[RPC_BEEP_UNMUTE_BIT] |=> !beep_muted)
    else $error("Beep path muted while its mute bit is one.");

  boost_follow_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce |=> mixer_boost_level == $past(pwr_r[RPC_BOOST_LSB +: RPC_MODE_W]))
    else $error("Mixer boost level does not follow its field.");

  adc_bias_enh_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && pwr_r[RPC_ADC_BIAS_LSB +: RPC_MODE_W] == RPC_CODE_ENHANCED |=> adc_bias_mode == RPC_MODE_ENHANCED)
    else $error("Converter bias code 11 is not enhanced performance.");

  fe_bias_extreme_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && pwr_r[RPC_FE_BIAS_LSB +: RPC_MODE_W] == RPC_CODE_EXTREME |=>
    front_end_bias_mode == RPC_MODE_EXTREME_SAVING)
    else $error("Front-end bias code 01 is not extreme power saving.");

  left_diff_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && !left_r[RPC_AMP_SE_BIT] |=>
    left_positive_diff_input_pin_en && !left_single_ended_input_pin_en && !left_complement_to_cm)
    else $error("Left differential mode not restored when single-ended bit is zero.");

  left_mute_on_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && !left_r[RPC_AMP_UNMUTE_BIT] |=> left_amp_muted)
    else $error("Left amplifier unmuted while its mute bit is zero.");

  left_power_on_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && left_r[RPC_AMP_EN_BIT] && !dmic_active |=> left_amp_powered)
    else $error("Left amplifier not powered while enabled.");

  right_unmute_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && right_r[RPC_AMP_UNMUTE_BIT] |=> !right_amp_muted)
    else $error("Right amplifier muted while its unmute bit is one.");

  right_power_off_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && !right_r[RPC_AMP_EN_BIT] |=> !right_amp_powered)
    else $error("Right amplifier powered while disabled.");

  reserved_beep_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && reg_rd_en && rpc_hit(reg_addr, RPC_IDX_BEEP) |=> (reg_rdata & ~RPC_MASK[RPC_IDX_BEEP]) == RPC_RD_NONE)
    else $error("Reserved bits of the mic and beep register read nonzero.");

  reserved_right_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && reg_rd_en && rpc_hit(reg_addr, RPC_IDX_RIGHT) |=> (reg_rdata & ~RPC_MASK[RPC_IDX_RIGHT]) == RPC_RD_NONE)
    else $error("Reserved bits of the right amplifier register read nonzero.");

  unmapped_read_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce && reg_rd_en && !rpc_hit(reg_addr, RPC_IDX_BEEP) && !rpc_hit(reg_addr, RPC_IDX_PWR) &&
    !rpc_hit(reg_addr, RPC_IDX_LEFT) && !rpc_hit(reg_addr, RPC_IDX_RIGHT) |=>
    reg_rvalid && reg_rdata == RPC_RD_NONE)
    else $error("Unmapped address read back nonzero.");

endmodule : rpc_regs
`default_nettype wire

// ### tb/tb.sv
// Self-checking testbench for the record path control register bank.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rpc_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic digital_mic_input_one_en, digital_mic_input_two_en, analog_front_end_pd, beep_muted;
  logic signed [6:0] beep_gain_db;
  logic [1:0] mixer_boost_level;
  rpc_pmode_t adc_bias_mode, front_end_bias_mode;
  logic [5:0] left_gain_db, right_gain_db;
  logic left_single_ended_input_pin_en, left_positive_diff_input_pin_en, left_complement_to_cm;
  logic left_amp_muted, left_amp_powered;
  logic right_single_ended_input_pin_en, right_positive_diff_input_pin_en, right_complement_to_cm;
  logic right_amp_muted, right_amp_powered;
  int num_errors = 0;
  int samples_checked = 0;
  logic [15:0] addrs [4] = '{16'h4008, 16'h4009, 16'h400e, 16'h400f};
  logic [7:0] masks [4] = '{8'h3f, 8'h7e, 8'he7, 8'he7};
  logic [7:0] beep_db [8] = '{8'h00, 8'h06, 8'h0a, 8'h0e, 8'he9, 8'h14, 8'h1a, 8'h20};
  logic [7:0] amp_db [8] = '{8'h00, 8'h06, 8'h0a, 8'h0e, 8'h11, 8'h14, 8'h1a, 8'h20};
  rpc_pmode_t bias_mode [4] = '{RPC_MODE_NORMAL, RPC_MODE_EXTREME_SAVING, RPC_MODE_POWER_SAVING, RPC_MODE_ENHANCED};

  rpc_regs dut (
    .ref_clk, .srst, .ce, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rvalid,
    .digital_mic_input_one_en, .digital_mic_input_two_en, .analog_front_end_pd, .beep_muted,
    .beep_gain_db, .mixer_boost_level, .adc_bias_mode, .front_end_bias_mode, .left_gain_db,
    .left_single_ended_input_pin_en, .left_positive_diff_input_pin_en, .left_complement_to_cm,
    .left_amp_muted, .left_amp_powered, .right_gain_db, .right_single_ended_input_pin_en,
    .right_positive_diff_input_pin_en, .right_complement_to_cm, .right_amp_muted, .right_amp_powered
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Decoded outputs settle one edge after the register takes the write, so wait for it.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01, "read answer");
    chk(reg_rdata, exp, "read data");
  endtask : rd

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({beep_muted, left_amp_muted, right_amp_muted, left_amp_powered, right_amp_powered, analog_front_end_pd,
         left_positive_diff_input_pin_en, right_positive_diff_input_pin_en}, 8'he3, "reset levels");
    chk({beep_gain_db[6], beep_gain_db}, 8'h00, "beep gain at reset");
    chk({left_gain_db, mixer_boost_level}, 8'h00, "left gain and boost at reset");
    chk({2'h0, right_gain_db}, 8'h00, "right gain at reset");
    chk({4'h0, adc_bias_mode, front_end_bias_mode}, 8'h00, "bias modes at reset");
    for (int i = 0; i < 4; i++) begin
      rd(addrs[i], 8'h00);
      wr(addrs[i], 8'hff);
      rd(addrs[i], masks[i]);
      wr(addrs[i], 8'h00);
    end
    // An unmapped address must neither answer with data nor disturb a neighbour.
    wr(16'h400d, 8'hff);
    rd(16'h400d, 8'h00);
    rd(16'h400e, 8'h00);
    for (int i = 0; i < 8; i++) begin
      // The beep mute bit is written as zero here, so the path must stay muted at every gain code.
      wr(16'h4008, {5'h00, 3'(i)});
      chk({beep_gain_db[6], beep_gain_db}, beep_db[i], "beep gain");
      chk({7'h00, beep_muted}, 8'h01, "beep muted");
    end
    wr(16'h4008, 8'h08);
    chk({7'h00, beep_muted}, 8'h00, "beep unmuted");
    for (int i = 0; i < 4; i++) begin
      wr(16'h4009, {1'b0, 2'(i), 2'(i), 2'(i), 1'b0});
      chk({6'h00, mixer_boost_level}, 8'(i), "mixer boost");
      chk({6'h00, adc_bias_mode}, {6'h00, bias_mode[i]}, "converter bias");
      chk({6'h00, front_end_bias_mode}, {6'h00, bias_mode[i]}, "front-end bias");
    end
    for (int i = 0; i < 8; i++) begin
      wr(16'h400e, {3'(i), 5'h00});
      wr(16'h400f, {3'(7 - i), 5'h00});
      chk({2'h0, left_gain_db}, amp_db[i], "left gain");
      chk({2'h0, right_gain_db}, amp_db[7 - i], "right gain");
    end
    for (int i = 0; i < 8; i++) begin
      wr(16'h400e, {5'h00, 3'(i)});
      wr(16'h400f, {5'h00, ~3'(i)});
      chk({3'h0, left_single_ended_input_pin_en, left_positive_diff_input_pin_en, left_complement_to_cm,
           left_amp_muted, left_amp_powered}, {3'h0, i[2], ~i[2], i[2], ~i[1], i[0]}, "left controls");
      chk({3'h0, right_single_ended_input_pin_en, right_positive_diff_input_pin_en, right_complement_to_cm,
           right_amp_muted, right_amp_powered}, {3'h0, ~i[2], i[2], ~i[2], i[1], ~i[0]}, "right controls");
    end
    // Both amplifiers are enabled here, so a digital mic must still force them off.
    wr(16'h400f, 8'h01);
    for (int m = 1; m < 5; m++) begin
      wr(16'h4008, {2'h0, 2'(m), 4'h0});
      chk({3'h0, digital_mic_input_one_en, digital_mic_input_two_en, analog_front_end_pd, left_amp_powered,
           right_amp_powered}, {3'h0, 2'(m) == 2'h1, 2'(m) == 2'h2, 2'(m) == 2'h1 || 2'(m) == 2'h2,
           !(2'(m) == 2'h1 || 2'(m) == 2'h2), !(2'(m) == 2'h1 || 2'(m) == 2'h2)}, "digital mic select");
    end
    // A write offered while the clock enable is low must be dropped.
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(16'h400e, 8'hff);
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(16'h400e, 8'h07);
    // A reset in mid-run must bring registers and decoded outputs back to their defaults.
    wr(16'h4009, 8'h60);
    chk({6'h00, mixer_boost_level}, 8'h03, "boost level three");
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({6'h00, mixer_boost_level}, 8'h00, "boost after reset");
    chk({6'h00, left_amp_muted, left_amp_powered}, 8'h02, "left amplifier after reset");
    rd(16'h4009, 8'h00);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
